// >>> hw/lane_parity.sv
// Per byte lane parity generation and check
module lane_parity #(
   parameter int lanes = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic odd_sense,
   input wire logic [lanes*8-1:0] data,
   input wire logic [lanes-1:0] parity_in,
   input wire logic [lanes-1:0] check_lanes,
   output logic [lanes-1:0] parity_out,
   output logic mismatch
);
   function automatic logic lane_bit(input logic [7:0] b, input logic odd);
      lane_bit = (^b) ^ odd;
   endfunction

   logic [lanes-1:0] gen;

   // Lane 0 is the most significant byte
   always_comb begin
      for (int i = 0; i < lanes; i++) begin
         gen[i] = lane_bit(data[(lanes-1-i)*8 +: 8], odd_sense);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         parity_out <= '0;
         mismatch <= 1'b0;
      end else begin
         parity_out <= gen;
         mismatch <= |((gen ^ parity_in) & check_lanes);
      end
   end
endmodule

// >>> hw/region_decode.sv
// Chip select region decode over address and space code
module region_decode #(
   parameter int regions = 8,
   parameter int addr_bits = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cycle_valid,
   input wire logic [addr_bits-1:0] address,
   input wire logic [3:0] space,
   input wire logic [regions*addr_bits-1:0] base,
   input wire logic [regions*addr_bits-1:0] mask,
   input wire logic [regions*4-1:0] space_match,
   input wire logic [regions*4-1:0] space_care,
   input wire logic [regions-1:0] enable,
   output logic [regions-1:0] hit
);
   logic [regions-1:0] next_hit;

   always_comb begin
      for (int r = 0; r < regions; r++) begin
         next_hit[r] = cycle_valid && enable[r]
            && (((address ^ base[r*addr_bits +: addr_bits]) & mask[r*addr_bits +: addr_bits]) == '0)
            && (((space ^ space_match[r*4 +: 4]) & space_care[r*4 +: 4]) == 4'h0);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hit <= '0;
      end else begin
         hit <= next_hit;
      end
   end
endmodule

// >>> hw/sysbus_pins.sv
// System bus pin functions: space code, data lanes, parity, strobes, interrupt priority
module sysbus_pins #(
   parameter int addr_bits = 32
) (
   input wire logic clk,
   input wire logic rst,
   // Internal masters
   input wire logic core_req,
   input wire logic [3:0] core_space,
   input wire logic independent_dma_unit_req,
   input wire logic [3:0] independent_dma_space,
   input wire logic serial_dma_unit_req,
   input wire logic [3:0] serial_dma_space,
   input wire logic refresh_req,
   input wire logic [3:0] refresh_space,
   input wire logic [addr_bits-1:0] cycle_address,
   input wire logic [1:0] cycle_size,
   input wire logic cycle_read,
   input wire logic [31:0] write_data,
   input wire logic ack_cycle,
   input wire logic [2:0] ack_level,
   input wire logic dram_cycle,
   input wire logic [6:0] row_active,
   output logic cycle_done_pulse,
   output logic [31:0] read_data,
   output logic [1:0] port_size,
   output logic bus_error,
   // External master
   input wire logic external_owns,
   input wire logic external_cycle,
   input wire logic [addr_bits-1:0] external_address,
   // Configuration
   input wire logic parity_even,
   input wire logic double_drive_en,
   input wire logic select7_is_ack,
   input wire logic column_is_ack,
   input wire logic [8*addr_bits-1:0] region_base,
   input wire logic [8*addr_bits-1:0] region_mask,
   input wire logic [31:0] region_space,
   input wire logic [31:0] region_space_care,
   input wire logic [7:0] region_enable,
   input wire logic [6:1] irq_mask,
   // Pins
   input wire logic [3:0] space_code_in,
   output logic [3:0] space_code_out,
   output logic space_code_oe,
   input wire logic [15:0] upper_data_lines_in,
   output logic [15:0] upper_data_lines_out,
   output logic upper_data_lines_oe,
   input wire logic [15:0] lower_data_lines_in,
   output logic [15:0] lower_data_lines_out,
   output logic lower_data_lines_oe,
   input wire logic [3:0] byte_parity_in,
   output logic [3:0] byte_parity_out,
   output logic [3:0] byte_parity_oe,
   input wire logic [1:0] size_acknowledge_n,
   output logic [6:0] chip_selects_n,
   output logic [6:0] row_strobes_n,
   output logic row_strobe1_double_drive_n,
   output logic row_strobe2_double_drive_n,
   output logic select7_or_ack7_pin_n,
   output logic [3:0] column_strobes_n,
   input wire logic [7:1] interrupt_requests_n,
   output logic [2:0] pending_level,
   output logic narrow_bus_mode
);
   logic [3:0] own_space;
   logic own_active;
   logic [3:0] lane_en;
   logic [7:0] hits;
   logic [3:0] bus_space;
   logic parity_mismatch;
   logic [31:0] bus_data;
   logic [3:0] check_lanes;
   logic strap_taken;
   sysbus_pkg::cycle_state_t state;
   sysbus_pkg::port_size_t ack_size;
   logic [addr_bits-1:0] decode_address;

   // Byte lane enables from transfer size, address and port width
   function automatic logic [3:0] lanes_for(input logic [1:0] size, input logic [1:0] a, input logic narrow);
      logic [3:0] l;
      l = 4'h0;
      case (size)
         sysbus_pkg::xfer_byte: l = 4'h1 << a;
         sysbus_pkg::xfer_word: l = a[1] ? 4'hC : 4'h3;
         sysbus_pkg::xfer_three: l = 4'hE >> (a == 2'h0 ? 2'd1 : 2'd0);
         default: l = 4'hF;
      endcase
      if (narrow) begin
         l = 4'h3;
      end
      lanes_for = l;
   endfunction

   // Space code chosen by the winning internal master; all-ones never leaves
   always_comb begin
      own_active = core_req | independent_dma_unit_req | serial_dma_unit_req | refresh_req;
      own_space = sysbus_pkg::space_sup_data;
      if (independent_dma_unit_req) begin
         own_space = independent_dma_space;
      end else if (serial_dma_unit_req) begin
         own_space = serial_dma_space;
      end else if (refresh_req) begin
         own_space = refresh_space;
      end else if (core_req) begin
         own_space = core_space;
      end
      if (own_space == sysbus_pkg::space_forbidden) begin
         own_space = sysbus_pkg::space_cpu;
      end
   end

   always_comb begin
      bus_space = external_owns ? space_code_in : own_space;
      decode_address = external_owns ? external_address : cycle_address;
      ack_size = sysbus_pkg::port_size_t'(~size_acknowledge_n);
      bus_data = {upper_data_lines_in, lower_data_lines_in};
   end

   region_decode #(.regions(sysbus_pkg::regions), .addr_bits(addr_bits)) u_decode (
      .clk(clk),
      .rst(rst),
      .cycle_valid((own_active && !external_owns) || (external_owns && external_cycle)),
      .address(decode_address),
      .space(bus_space),
      .base(region_base),
      .mask(region_mask),
      .space_match(region_space),
      .space_care(region_space_care),
      .enable(region_enable),
      .hit(hits)
   );

   lane_parity #(.lanes(sysbus_pkg::lane_count)) u_parity (
      .clk(clk),
      .rst(rst),
      .odd_sense(~parity_even),
      .data(cycle_read || external_owns ? bus_data : write_data),
      .parity_in(byte_parity_in),
      .check_lanes(check_lanes),
      .parity_out(byte_parity_out),
      .mismatch(parity_mismatch)
   );

   // Width strap caught on the first edge after reset; lane 3 pull-up gives wide mode
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_taken <= 1'b0;
         narrow_bus_mode <= sysbus_pkg::reset_narrow_mode;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         narrow_bus_mode <= ~byte_parity_in[3];
      end
   end

   // Cycle sequencing, ended by the slave size acknowledge
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= sysbus_pkg::cycle_idle;
         lane_en <= 4'h0;
         cycle_done_pulse <= 1'b0;
         port_size <= 2'b00;
         read_data <= 32'h0000_0000;
      end else begin
         cycle_done_pulse <= 1'b0;
         case (state)
            sysbus_pkg::cycle_idle: begin
               if (own_active && !external_owns && strap_taken) begin
                  lane_en <= lanes_for(cycle_size, cycle_address[1:0], narrow_bus_mode);
                  state <= sysbus_pkg::cycle_run;
               end
            end
            sysbus_pkg::cycle_run: begin
               if (ack_size != sysbus_pkg::port_wait) begin
                  port_size <= ack_size;
                  read_data <= bus_data;
                  cycle_done_pulse <= 1'b1;
                  state <= sysbus_pkg::cycle_done;
               end
            end
            default: begin
               lane_en <= 4'h0;
               state <= sysbus_pkg::cycle_idle;
            end
         endcase
      end
   end

   // Pin drive: space code and data float while an outside master owns the bus
   always_ff @(posedge clk) begin
      if (rst) begin
         space_code_out <= 4'h0;
         space_code_oe <= 1'b0;
         upper_data_lines_out <= 16'h0000;
         upper_data_lines_oe <= 1'b0;
         lower_data_lines_out <= 16'h0000;
         lower_data_lines_oe <= 1'b0;
         byte_parity_oe <= 4'h0;
         check_lanes <= 4'h0;
      end else begin
         space_code_out <= own_space;
         space_code_oe <= own_active && !external_owns;
         upper_data_lines_out <= write_data[31:16];
         lower_data_lines_out <= write_data[15:0];
         upper_data_lines_oe <= own_active && !external_owns && !cycle_read;
         lower_data_lines_oe <= own_active && !external_owns && !cycle_read && !narrow_bus_mode;
         byte_parity_oe <= (own_active && !external_owns && !cycle_read)
            ? (narrow_bus_mode ? 4'h3 : 4'hF) : 4'h0;
         check_lanes <= (cycle_read || external_owns) && state == sysbus_pkg::cycle_run
            && ack_size != sysbus_pkg::port_wait ? lane_en : 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_error <= 1'b0;
      end else begin
         bus_error <= parity_mismatch;
      end
   end

   // Memory strobes and acknowledge strobes sharing pins
   always_ff @(posedge clk) begin
      if (rst) begin
         chip_selects_n <= 7'h7F;
         row_strobes_n <= 7'h7F;
         row_strobe1_double_drive_n <= 1'b1;
         row_strobe2_double_drive_n <= 1'b1;
         select7_or_ack7_pin_n <= 1'b1;
         column_strobes_n <= 4'hF;
      end else begin
         chip_selects_n <= dram_cycle ? 7'h7F : ~hits[6:0];
         row_strobes_n <= dram_cycle ? ~(row_active & hits[6:0]) : 7'h7F;
         row_strobe1_double_drive_n <= !(double_drive_en && dram_cycle && row_active[1] && hits[1]);
         row_strobe2_double_drive_n <= !(double_drive_en && dram_cycle && row_active[2] && hits[2]);
         if (select7_is_ack) begin
            select7_or_ack7_pin_n <= !(ack_cycle && ack_level == sysbus_pkg::ack_level_top);
         end else begin
            select7_or_ack7_pin_n <= !hits[7];
         end
         if (column_is_ack) begin
            column_strobes_n <= ~{ack_cycle && ack_level == 3'd6, ack_cycle && ack_level == 3'd3,
                                  ack_cycle && ack_level == 3'd2, ack_cycle && ack_level == 3'd1};
         end else begin
            column_strobes_n <= dram_cycle && state == sysbus_pkg::cycle_run ? ~lane_en : 4'hF;
         end
      end
   end

   // Priority encoder: level 7 cannot be masked
   always_ff @(posedge clk) begin
      if (rst) begin
         pending_level <= 3'h0;
      end else begin
         pending_level <= 3'h0;
         if (!interrupt_requests_n[7]) begin
            pending_level <= 3'h7;
         end else begin
            for (int l = 1; l <= 6; l++) begin
               if (!interrupt_requests_n[l] && !irq_mask[l]) begin
                  pending_level <= 3'(l);
               end
            end
         end
      end
   end
endmodule

// >>> hw/sysbus_pkg.sv
// Constants and types shared by the system bus pin block
package sysbus_pkg;
   localparam int regions = 8;
   localparam logic [3:0] space_forbidden = 4'hF;
   localparam logic [3:0] space_cpu = 4'h7;
   localparam logic [3:0] space_user_data = 4'h1;
   localparam logic [3:0] space_sup_data = 4'h5;
   localparam logic [3:0] space_sup_program = 4'h6;
   localparam logic [3:0] space_dma_base = 4'h8;
   localparam int space_dma_bit = 3;
   localparam logic reset_parity_odd = 1'b1;
   localparam logic reset_narrow_mode = 1'b0;
   localparam int lane_count = 4;
   localparam logic [2:0] ack_level_top = 3'h7;

   typedef enum logic [1:0] {
      port_wait = 2'b00,
      port_8 = 2'b01,
      port_16 = 2'b10,
      port_32 = 2'b11
   } port_size_t;

   typedef enum logic [1:0] {
      xfer_long = 2'b00,
      xfer_byte = 2'b01,
      xfer_word = 2'b10,
      xfer_three = 2'b11
   } xfer_size_t;

   typedef enum logic [1:0] {
      cycle_idle = 2'b00,
      cycle_run = 2'b01,
      cycle_done = 2'b10
   } cycle_state_t;

   typedef enum logic [2:0] {
      master_core = 3'b000,
      master_independent_dma_unit = 3'b001,
      master_serial_dma_unit = 3'b010,
      master_refresh = 3'b011,
      master_external = 3'b100
   } master_t;
endpackage

// >>> tb/bus_slave.sv
// Slave model: answers cycles with size acknowledge, read data and lane parity
module bus_slave (
   input wire logic clk,
   input wire logic cyc,
   input wire logic done,
   input wire logic [1:0] code,
   input wire logic [3:0] wt,
   input wire logic [31:0] word,
   input wire logic [3:0] bad,
   input wire logic strap,
   output logic [1:0] ack_n,
   output logic [31:0] data,
   output logic [3:0] par
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   initial ack_n = 2'h3;
   initial data = 32'h0;
   always @(posedge clk) begin
      if (!cyc || done) begin
         cnt <= 4'h0;
         ack_n <= 2'h3;
      end else if (cnt == wt) ack_n <= code;
      else cnt <= cnt + 4'h1;
      // Released lines must not keep the last value
      data <= cyc ? word : ~data;
   end
   // Odd parity per lane; idle lines sit at the pulled level, lane 3 is the strap
   always_comb for (int i = 0; i < 4; i++) par[i] = cyc ? ~^data[31-8*i -: 8] ^ bad[i] : strap;
endmodule

// >>> tb/sysbus_monitor.sv
// Checker for the system bus pin block, bound to its top module
module sysbus_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] space_code_out,
   input wire logic space_code_oe,
   input wire logic external_owns,
   input wire logic narrow_bus_mode,
   input wire logic lower_data_lines_oe,
   input wire logic double_drive_en,
   input wire logic [6:0] row_strobes_n,
   input wire logic row_strobe1_double_drive_n,
   input wire logic row_strobe2_double_drive_n,
   input wire logic column_is_ack,
   input wire logic select7_is_ack,
   input wire logic ack_cycle,
   input wire logic [2:0] ack_level,
   input wire logic [3:0] column_strobes_n,
   input wire logic select7_or_ack7_pin_n,
   input wire logic [7:1] interrupt_requests_n,
   input wire logic [2:0] pending_level,
   input wire logic [1:0] size_acknowledge_n,
   input wire logic cycle_done_pulse,
   input wire logic [1:0] port_size
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_slave_ack;
      space_code_oe && size_acknowledge_n != 2'h3 && !cycle_done_pulse;
   endsequence
   sequence s_one_pulse;
      cycle_done_pulse ##1 !cycle_done_pulse;
   endsequence
   a_done_pulse: assert property (s_slave_ack |=> s_one_pulse)
      else $error("cycle end is not a single pulse after acknowledge");
   a_port_size: assert property (cycle_done_pulse |-> port_size == ~$past(size_acknowledge_n))
      else $error("port size differs from acknowledge code");
   a_no_all_ones: assert property (space_code_oe |-> space_code_out != 4'hF)
      else $error("all ones space code driven");
   a_ext_release: assert property (external_owns && $past(external_owns) |-> !space_code_oe)
      else $error("space code driven while external master owns bus");
   a_narrow_lower: assert property (narrow_bus_mode |-> !lower_data_lines_oe)
      else $error("lower lines driven in narrow mode");
   a_double_drive: assert property (double_drive_en && $past(double_drive_en) |->
      row_strobe1_double_drive_n == row_strobes_n[1] && row_strobe2_double_drive_n == row_strobes_n[2])
      else $error("double drive pin differs from row strobe");
   a_column_ack: assert property ($past(column_is_ack && ack_cycle && ack_level == 3'h6) |->
      column_strobes_n == 4'h7)
      else $error("level 6 acknowledge not on column strobe 3");
   a_ack7_strobe: assert property ((select7_is_ack && ack_cycle && ack_level == 3'h7) [*2] |->
      !select7_or_ack7_pin_n)
      else $error("level 7 acknowledge strobe missing");
   a_nmi_level: assert property (!interrupt_requests_n[7] [*2] |-> pending_level == 3'h7)
      else $error("level 7 request not on top");
endmodule
bind sysbus_pins sysbus_monitor mon (.*);

// >>> tb/testbench.sv
// Self-checking testbench for the system bus pin block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, core_req, independent_dma_unit_req, serial_dma_unit_req, refresh_req, cycle_read, ack_cycle, dram_cycle, cycle_done_pulse;
   logic bus_error, external_owns, external_cycle, parity_even, double_drive_en, select7_is_ack, column_is_ack;
   logic space_code_oe, upper_data_lines_oe, lower_data_lines_oe, row_strobe1_double_drive_n;
   logic row_strobe2_double_drive_n, select7_or_ack7_pin_n, narrow_bus_mode, strap, cs_seen, low_seen;
   logic [3:0] core_space, independent_dma_space, serial_dma_space, refresh_space, space_code_in, space_code_out;
   logic [3:0] byte_parity_in, byte_parity_out, byte_parity_oe, column_strobes_n, wt, bad, seen, sp, ext_space, cols;
   logic [31:0] cycle_address, write_data, read_data, external_address, region_space, region_space_care, word, sd;
   logic [1:0] cycle_size, port_size, size_acknowledge_n, ack;
   logic [2:0] ack_level, pending_level;
   logic [6:0] row_active, chip_selects_n, row_strobes_n;
   logic [255:0] region_base, region_mask;
   logic [7:0] region_enable;
   logic [6:1] irq_mask;
   logic [15:0] upper_data_lines_in, upper_data_lines_out, lower_data_lines_in, lower_data_lines_out;
   logic [7:1] interrupt_requests_n;
   int n_fail, n_compared;
   sysbus_pins DUT (.*);
   bus_slave sl (.clk, .cyc(space_code_oe), .done(cycle_done_pulse), .code(ack), .wt, .word, .bad, .strap,
      .ack_n(size_acknowledge_n), .data(sd), .par(sp));
   assign upper_data_lines_in = upper_data_lines_oe ? upper_data_lines_out : sd[31:16];
   assign lower_data_lines_in = lower_data_lines_oe ? lower_data_lines_out : sd[15:0];
   assign byte_parity_in = byte_parity_oe & byte_parity_out | ~byte_parity_oe & sp;
   assign space_code_in = space_code_oe ? space_code_out : ext_space;
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (space_code_oe) seen <= space_code_out;
      if (!chip_selects_n[0]) cs_seen <= 1'h1;
      if (lower_data_lines_oe) low_seen <= 1'h1;
      if (column_strobes_n != 4'hF) cols <= column_strobes_n;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task do_reset;
      rst = 1;
      repeat (16) @(negedge clk);
      rst = 0;
      repeat (2) @(negedge clk);
   endtask
   task run(input int m, input logic [3:0] s, input logic [1:0] a);
      int i;
      @(negedge clk);
      case (m)
         0: core_space = s;
         1: independent_dma_space = s;
         2: serial_dma_space = s;
         default: refresh_space = s;
      endcase
      ack = a;
      cs_seen = 0;
      {refresh_req, serial_dma_unit_req, independent_dma_unit_req, core_req} = 4'h1 << m;
      for (i = 0; i < 40 && cycle_done_pulse !== 1'h1; i++) @(negedge clk);
      {refresh_req, serial_dma_unit_req, independent_dma_unit_req, core_req} = 4'h0;
      chk(i < 40, 1'h1, "cycle never ended");
   endtask
   task t_read;
      wt = 4'h3;
      low_seen = 0;
      run(0, 4'h5, 2'h0);
      chk(read_data, word, "read data");
      chk(cs_seen, 1'h1, "boot select");
      cycle_read = 0;
      run(0, 4'h5, 2'h0);
      chk(low_seen, 1'h1, "lower lines in long write");
      cycle_read = 1;
      wt = 4'h0;
      $display("t_read done");
   endtask
   task t_codes;
      logic [3:0] c[6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'hF};
      logic [1:0] a[3] = '{2'h2, 2'h1, 2'h0};
      foreach (c[i]) begin
         run(0, c[i], a[i%3]);
         chk(seen, c[i] == 4'hF ? 4'h7 : c[i], "space code");
         chk(port_size, {~a[i%3]}, "dynamic size");
      end
      for (int m = 1; m < 4; m++) begin
         run(m, {2'h2, m[1:0]}, 2'h0);
         chk(seen, {2'h2, m[1:0]}, "internal master code");
      end
      $display("t_codes done");
   endtask
   task t_parity;
      for (int l = 0; l < 5; l++) begin
         bad = 4'h1 << l;
         run(0, 4'h5, 2'h0);
         // Error flag lands two edges after the end pulse
         repeat (2) @(negedge clk);
         chk(bus_error, l < 4, "parity check");
      end
      $display("t_parity done");
   endtask
   task t_ext;
      external_owns = 1;
      ext_space = 4'h5;
      repeat (3) @(negedge clk);
      chk(space_code_oe, 1'h0, "lines released");
      cs_seen = 0;
      external_cycle = 1;
      repeat (3) @(negedge clk);
      chk(cs_seen, 1'h1, "external select");
      ext_space = 4'h1;
      repeat (2) @(negedge clk);
      cs_seen = 0;
      repeat (2) @(negedge clk);
      chk(cs_seen, 1'h0, "space mismatch select");
      external_cycle = 0;
      external_owns = 0;
      $display("t_ext done");
   endtask
   task t_strobes;
      logic [2:0] lv[5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      logic [4:0] ex[5] = '{5'h1E, 5'h1D, 5'h1B, 5'h17, 5'h0F};
      dram_cycle = 1;
      cycle_size = 2'h1;
      cols = 4'hF;
      run(0, 4'h5, 2'h0);
      chk(cols, 4'hE, "column strobe lane");
      cycle_size = 2'h0;
      // Decode only runs on a valid cycle, so borrow an outside master on open regions 1 and 2
      {external_owns, external_cycle} = 2'h3;
      region_enable = 8'h07;
      row_active = 7'h06;
      double_drive_en = 1;
      repeat (2) @(negedge clk);
      chk({row_strobe2_double_drive_n, row_strobe1_double_drive_n, row_strobes_n[2:1]}, 4'h0, "double drive");
      dram_cycle = 0;
      {external_owns, external_cycle} = 2'h0;
      region_enable = 8'h01;
      {column_is_ack, select7_is_ack, ack_cycle} = 3'h7;
      foreach (lv[i]) begin
         ack_level = lv[i];
         repeat (2) @(negedge clk);
         chk({select7_or_ack7_pin_n, column_strobes_n}, ex[i], "acknowledge strobe");
      end
      {column_is_ack, select7_is_ack, ack_cycle} = 3'h0;
      $display("t_strobes done");
   endtask
   task t_irq;
      logic [6:0] rq[3] = '{7'h5F, 7'h1F, 7'h5D};
      logic [5:0] mk[3] = '{6'h3F, 6'h3F, 6'h00};
      logic [2:0] ex[3] = '{3'h0, 3'h7, 3'h6};
      foreach (rq[i]) begin
         interrupt_requests_n = rq[i];
         irq_mask = mk[i];
         repeat (2) @(negedge clk);
         chk(pending_level, ex[i], "pending level");
      end
      interrupt_requests_n = 7'h7F;
      $display("t_irq done");
   endtask
   task t_narrow;
      strap = 0;
      do_reset;
      chk(narrow_bus_mode, 1'h1, "narrow strap");
      low_seen = 0;
      cycle_read = 0;
      run(0, 4'h5, 2'h2);
      chk(low_seen, 1'h0, "lower lines idle");
      $display("t_narrow done");
   endtask
   initial begin
      {rst, strap, cycle_read, interrupt_requests_n} = 10'h3FF;
      {core_req, independent_dma_unit_req, serial_dma_unit_req, refresh_req, ack_cycle, dram_cycle, external_owns, external_cycle} = 8'h0;
      {parity_even, double_drive_en, select7_is_ack, column_is_ack, irq_mask, ack_level, row_active} = 20'h0;
      {core_space, independent_dma_space, serial_dma_space, refresh_space, ext_space} = 20'h2_2222;
      {wt, bad, ack, cycle_size} = 12'h0;
      cycle_address = 32'h0000_0100;
      external_address = 32'h0000_0040;
      write_data = 32'h3C5A_96E1;
      word = 32'hA5C3_0F96;
      region_base = 256'h0;
      region_mask = {224'h0, 32'hFFFF_0000};
      region_space = 32'h5;
      region_space_care = 32'hF;
      region_enable = 8'h01;
      {cs_seen, low_seen, seen, cols} = 10'h00F;
      do_reset;
      chk(narrow_bus_mode, 1'h0, "wide strap");
      t_read;
      t_codes;
      t_parity;
      t_ext;
      t_strobes;
      t_irq;
      t_narrow;
      tally_and_finish;
   end
   initial begin
      #(4000 * 25);
      n_fail++;
      tally_and_finish;
   end
endmodule
